/* fsl_pkg.sv */
// Notes on behaviour
// - steady function drives the channel at full 100 percent amplitude.
// - dimming sets amplitude 1..99 percent in 1 percent steps, monotonic.
// - blinking toggles at 0.1..9.9 Hz in 0.1 Hz steps.
// - flashing repeats at a fixed 1 Hz.
// - flash pulse width is 1..99 ms in 1 ms steps.
// - off function keeps the channel dark.
// - five operating modes, each holding settings for all channels.
// - every channel gets its own function in every mode.
// - mode chosen by contacts; no contact active selects mode 1.
// - several active contacts select the highest mode number.
// - external flashing inputs override every operating mode.
// - two flashing inputs with a configurable priority between them.
// - rising edge on governing input switches all channels to steady.
// - no edge for 2 seconds returns channels to their mode functions.
// - power fault disables only that channel at once; rate fault does not.
// - display shows E0, channel, cause; blank without fault.
// - one failure rate threshold for all channels, 1..99 percent.
// - reference current re-read after reset, settings change, new units.
// - fault relay shows error on fault and when idle or unpowered.
// - DIP switch 8 selects single or collective fault reporting.
// - single reporting drives only the faulty channel's relay and LED.
// - collective reporting drives all relays, only the faulty LED.
// - fault stays latched until local key or remote reset command.
package fsl_pkg;
   localparam int NCH = 4;
   localparam int NMODE = 5;
   localparam int NCFG = 20;
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
   localparam int OVR_S = 2;
   localparam logic [10:0] OVR_MS = 11'(OVR_S * 1000);
   localparam int FLASH_HZ = 1;
   localparam logic [9:0] FLASH_PER_MS = 10'(1000 / FLASH_HZ);
   localparam logic [12:0] BLINK_HALF = 13'h1388;
   localparam logic [6:0] AMP_FULL = 7'h64;
   localparam logic [6:0] VAL_MIN = 7'h01;
   localparam logic [6:0] VAL_MAX = 7'h63;
   localparam logic [6:0] THR_RST = 7'h14;
   localparam logic [6:0] CFG_VAL_RST = 7'h32;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_THR = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_FLT = 8'h0C;
   localparam logic [7:0] A_CFG = 8'h40;
   localparam logic [7:0] A_CFG_END = 8'h90;
   localparam int CTRL_PRIO = 0;
   localparam int CTRL_CLR = 1;
   localparam logic [1:0] C_RATE = 2'h0;
   localparam logic [1:0] C_PWR = 2'h1;
   localparam logic [1:0] C_INT = 2'h2;
   localparam logic [3:0] DG_E = 4'hE;
   localparam logic [3:0] DG_BLANK = 4'hF;
   localparam logic [15:0] DISP_BLANK = 16'hFFFF;

   typedef enum logic [2:0] {FN_STEADY, FN_DIM, FN_BLINK, FN_FLASH, FN_OFF} fsl_func_e;

   typedef struct packed {
      fsl_func_e func;
      logic [6:0] val;
   } fsl_cfg_s;

   typedef struct packed {
      logic [3:0] hw_fault;
      logic [3:0] int_err;
      logic [3:0] connect;
      logic [3:0][7:0] cur;
   } fsl_chin_s;

   typedef struct packed {
      logic [3:0] relay_ok;
      logic [3:0] led;
      logic [15:0] disp;
   } fsl_flt_s;

   typedef struct packed {
      fsl_cfg_s [NCFG-1:0] cfg;
      logic prio;
      logic [6:0] thr;
      logic [31:0] tick;
      logic ms;
      logic [9:0] fl_ms;
      logic [3:0][12:0] b_acc;
      logic [3:0] b_ph;
      logic [1:0] in_prev;
      logic [1:0] in_lvl;
      logic [1:0][10:0] in_tmr;
      logic [3:0] f_v;
      logic [3:0][1:0] f_c;
      logic [3:0][7:0] refc;
      logic [3:0] ref_req;
      logic [3:0][6:0] amp;
      fsl_flt_s flt;
   } fsl_state_s;
endpackage

/* fsl_lamp_ctrl.sv */
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module fsl_lamp_ctrl
   import fsl_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // contacts and switches
   input wire logic [4:0] mode_contact,
   input wire logic [1:0] flash_in,
   input wire logic dip_collective,
   input wire logic reset_key,
   // channel sensing
   input fsl_chin_s chin,
   // lamp and fault outputs
   output logic [3:0][6:0] lamp_amp,
   output fsl_flt_s flt
);
   fsl_state_s st_r;
   fsl_state_s st_nxt;
   logic [2:0] mode_sel;
   logic ovr_act;
   logic ovr_lvl;
   logic gov;
   logic wr_ok;
   logic clr_cmd;

   function automatic logic [6:0] clamp(input logic [6:0] v);
      clamp = (v < VAL_MIN) ? VAL_MIN : ((v > VAL_MAX) ? VAL_MAX : v);
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) &&
         (a <= A_FLT || (a >= A_CFG && a < A_CFG_END));
   endfunction

   function automatic logic [4:0] cfg_idx(input logic [2:0] m, input int c);
      cfg_idx = 5'(m * 3'h4 + 5'(c));
   endfunction

   function automatic logic pwr_dis(input fsl_state_s s, input logic hw, input int c);
      pwr_dis = hw | (s.f_v[c] & (s.f_c[c] == C_PWR));
   endfunction

   // ------------------------------------------------------------
   // mode and override selection
   // ------------------------------------------------------------
   always_comb
   begin
      mode_sel = 3'h0;
      for (int i = 1; i < NMODE; i++)
      begin
         if (mode_contact[i])
         begin
            mode_sel = 3'(i);
         end
      end
   end

   // governing input: preferred one while it toggles, else the other
   assign gov = (st_r.in_tmr[st_r.prio] < OVR_MS) ? st_r.prio : ~st_r.prio;
   assign ovr_act = (st_r.in_tmr[0] < OVR_MS) || (st_r.in_tmr[1] < OVR_MS);
   assign ovr_lvl = st_r.in_lvl[gov];
   assign wr_ok = psel && penable && pwrite && addr_ok(paddr);
   assign clr_cmd = reset_key || (wr_ok && paddr == A_CTRL && pwdata[CTRL_CLR]);

   // ------------------------------------------------------------
   // apb read side
   // ------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);

   always_comb
   begin
      prdata = 32'h0;
      if (psel && addr_ok(paddr))
      begin
         if (paddr == A_CTRL)
         begin
            prdata[CTRL_PRIO] = st_r.prio;
         end
         else if (paddr == A_THR)
         begin
            prdata[6:0] = st_r.thr;
         end
         else if (paddr == A_STAT)
         begin
            prdata[8:0] = {st_r.ref_req, ovr_lvl, ovr_act, mode_sel};
         end
         else if (paddr == A_FLT)
         begin
            prdata[27:0] = {st_r.flt.disp, st_r.f_c, st_r.f_v};
         end
         else
         begin
            prdata[9:0] = st_r.cfg[5'((paddr - A_CFG) >> 2)];
         end
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      fsl_func_e f;
      logic [6:0] v;
      logic [6:0] a;
      logic [14:0] lhs;
      logic [14:0] rhs;
      logic set;
      logic [1:0] cause;
      logic [12:0] acc;
      logic rearm;
      st_nxt = st_r;
      f = FN_OFF;
      v = 7'h0;
      a = 7'h0;
      lhs = 15'h0;
      rhs = 15'h0;
      set = 1'b0;
      cause = C_RATE;
      acc = 13'h0;
      rearm = 1'b0;
      // millisecond time base
      st_nxt.ms = 1'b0;
      if (st_r.tick >= 32'(TICK_CYC - 1))
      begin
         st_nxt.tick = 32'h0;
         st_nxt.ms = 1'b1;
      end
      else
      begin
         st_nxt.tick = st_r.tick + 32'h1;
      end
      if (st_r.ms)
      begin
         // fixed flash period
         st_nxt.fl_ms = (st_r.fl_ms == FLASH_PER_MS - 10'h1) ? 10'h0 : st_r.fl_ms + 10'h1;
         for (int k = 0; k < 2; k++)
         begin
            if (st_r.in_tmr[k] < OVR_MS)
            begin
               st_nxt.in_tmr[k] = st_r.in_tmr[k] + 11'h1;
            end
         end
      end
      // flashing input edges restart the hold timer
      for (int k = 0; k < 2; k++)
      begin
         if (flash_in[k] != st_r.in_prev[k])
         begin
            st_nxt.in_tmr[k] = 11'h0;
            st_nxt.in_lvl[k] = flash_in[k];
         end
      end
      st_nxt.in_prev = flash_in;
      // register writes
      if (wr_ok)
      begin
         if (paddr == A_CTRL)
         begin
            st_nxt.prio = pwdata[CTRL_PRIO];
         end
         else if (paddr == A_THR)
         begin
            st_nxt.thr = clamp(pwdata[6:0]);
            st_nxt.ref_req = 4'hF;
            rearm = 1'b1;
         end
         else if (paddr >= A_CFG)
         begin
            st_nxt.cfg[5'((paddr - A_CFG) >> 2)].func = (pwdata[2:0] > 3'(FN_OFF)) ?
               FN_OFF : fsl_func_e'(pwdata[2:0]);
            st_nxt.cfg[5'((paddr - A_CFG) >> 2)].val = clamp(pwdata[9:3]);
            st_nxt.ref_req = 4'hF;
            rearm = 1'b1;
         end
      end
      // per-channel lamp drive and fault supervision
      for (int c = 0; c < NCH; c++)
      begin
         f = st_r.cfg[cfg_idx(mode_sel, c)].func;
         v = st_r.cfg[cfg_idx(mode_sel, c)].val;
         case (f)
            FN_STEADY: a = AMP_FULL;
            FN_DIM: a = v;
            FN_BLINK: a = st_r.b_ph[c] ? AMP_FULL : 7'h0;
            FN_FLASH: a = (st_r.fl_ms < 10'(v)) ? AMP_FULL : 7'h0;
            FN_OFF: a = 7'h0;
            default: a = 7'h0;
         endcase
         if (ovr_act)
         begin
            a = ovr_lvl ? AMP_FULL : 7'h0;
         end
         st_nxt.amp[c] = pwr_dis(st_r, chin.hw_fault[c], c) ? 7'h0 : a;
         // blink phase accumulator in 0.1 Hz units per ms
         if (f != FN_BLINK)
         begin
            st_nxt.b_acc[c] = 13'h0;
            st_nxt.b_ph[c] = 1'b1;
         end
         else if (st_r.ms)
         begin
            acc = st_r.b_acc[c] + 13'(v);
            if (acc >= BLINK_HALF)
            begin
               st_nxt.b_acc[c] = acc - BLINK_HALF;
               st_nxt.b_ph[c] = ~st_r.b_ph[c];
            end
            else
            begin
               st_nxt.b_acc[c] = acc;
            end
         end
         // reference capture and rate check at full drive only
         lhs = 15'(chin.cur[c]) * 15'h64;
         rhs = 15'(st_r.refc[c]) * 15'(AMP_FULL - st_r.thr);
         if (chin.connect[c])
         begin
            st_nxt.ref_req[c] = 1'b1;
         end
         // a settings write in this cycle outranks the capture
         else if (st_r.ms && st_r.amp[c] == AMP_FULL && st_r.ref_req[c] && !rearm)
         begin
            st_nxt.refc[c] = chin.cur[c];
            st_nxt.ref_req[c] = 1'b0;
         end
         set = 1'b1;
         if (chin.hw_fault[c])
         begin
            cause = C_PWR;
         end
         else if (chin.int_err[c])
         begin
            cause = C_INT;
         end
         else if (st_r.ms && st_r.amp[c] == AMP_FULL && !st_r.ref_req[c] && lhs < rhs)
         begin
            cause = C_RATE;
         end
         else
         begin
            set = 1'b0;
         end
         if (clr_cmd)
         begin
            st_nxt.f_v[c] = 1'b0;
         end
         if (set && (clr_cmd || !st_r.f_v[c]))
         begin
            st_nxt.f_v[c] = 1'b1;
            st_nxt.f_c[c] = cause;
         end
      end
      // relays energised means healthy
      st_nxt.flt.relay_ok = dip_collective ? {4{~|st_nxt.f_v}} : ~st_nxt.f_v;
      st_nxt.flt.led = st_nxt.f_v;
      st_nxt.flt.disp = DISP_BLANK;
      for (int c = NCH - 1; c >= 0; c--)
      begin
         if (st_nxt.f_v[c])
         begin
            st_nxt.flt.disp = {DG_E, 4'h0, 4'(c + 1), 2'h0, st_nxt.f_c[c]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
         for (int i = 0; i < NCFG; i++)
         begin
            st_r.cfg[i].val <= CFG_VAL_RST;
         end
         st_r.thr <= THR_RST;
         st_r.in_tmr <= {OVR_MS, OVR_MS};
         st_r.b_ph <= 4'hF;
         st_r.ref_req <= 4'hF;
         st_r.flt.disp <= DISP_BLANK;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign lamp_amp = st_r.amp;
   assign flt = st_r.flt;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   steady_full_a: assert property (!ovr_act && !pwr_dis(st_r, chin.hw_fault[0], 0) &&
      st_r.cfg[cfg_idx(mode_sel, 0)].func == FN_STEADY |=> lamp_amp[0] == AMP_FULL)
      else $error("steady channel not at full amplitude");
   dim_level_a: assert property (!ovr_act && !pwr_dis(st_r, chin.hw_fault[1], 1) &&
      st_r.cfg[cfg_idx(mode_sel, 1)].func == FN_DIM
      |=> lamp_amp[1] == $past(st_r.cfg[cfg_idx(mode_sel, 1)].val))
      else $error("dimmed amplitude differs from setting");
   off_dark_a: assert property (!ovr_act &&
      st_r.cfg[cfg_idx(mode_sel, 2)].func == FN_OFF |=> lamp_amp[2] == 7'h0)
      else $error("off channel is lit");
   mode_high_a: assert property (mode_contact[4] |-> mode_sel == 3'h4)
      else $error("highest mode contact not selected");
   mode_default_a: assert property (mode_contact == 5'h0 |-> mode_sel == 3'h0)
      else $error("mode 1 not default");
   ovr_on_a: assert property ($rose(flash_in[0]) && !st_r.prio &&
      !pwr_dis(st_r, chin.hw_fault[3], 3) && !chin.hw_fault[3] ##1 !chin.hw_fault[3]
      |=> lamp_amp[3] == AMP_FULL)
      else $error("rising flash edge did not light channel");
   ovr_off_a: assert property ($fell(flash_in[0]) && !st_r.prio
      |-> ##2 lamp_amp[3] == 7'h0)
      else $error("falling flash edge did not darken channel");
   ovr_end_a: assert property (st_r.in_tmr[0] >= OVR_MS && st_r.in_tmr[1] >= OVR_MS &&
      !pwr_dis(st_r, chin.hw_fault[0], 0) && st_r.cfg[cfg_idx(mode_sel, 0)].func == FN_STEADY
      |=> lamp_amp[0] == AMP_FULL)
      else $error("override held after idle time");
   pwr_cut_a: assert property (chin.hw_fault[3] && (!st_r.f_v[3] || clr_cmd)
      |=> lamp_amp[3] == 7'h0 && st_r.f_v[3] && st_r.f_c[3] == C_PWR)
      else $error("power fault did not disable channel");
   latch_hold_a: assert property (st_r.f_v[3] && !clr_cmd |=> st_r.f_v[3])
      else $error("fault dropped without reset");
   coll_relay_a: assert property (dip_collective && |st_r.f_v && !clr_cmd
      |=> flt.relay_ok == 4'h0 && flt.led == st_r.f_v)
      else $error("collective relays not all in error");
   single_relay_a: assert property (!dip_collective && !st_r.f_v[0] && !clr_cmd ##1
      !dip_collective && !st_r.f_v[0] |-> flt.relay_ok[0])
      else $error("healthy channel relay in error");
   blank_disp_a: assert property (st_r.f_v == 4'h0 |-> flt.disp == DISP_BLANK)
      else $error("display not blank without fault");

   ovr_seen_c: cover property ($rose(flash_in[0]) ##[1:20] $fell(flash_in[0]));
   fault_clr_c: cover property (st_r.f_v[0] ##1 clr_cmd ##1 !st_r.f_v[0]);
   blink_c: cover property (st_r.cfg[cfg_idx(mode_sel, 0)].func == FN_BLINK && $rose(lamp_amp[0][6]));
endmodule

/* fsl_lamp_chain.sv */
`timescale 1ns/100ps
module fsl_lamp_chain
   import fsl_pkg::*;
(
   // lamp drive in
   input wire logic [3:0][6:0] lamp_amp,
   input wire logic [3:0] fault_req,
   input wire logic [3:0] int_req,
   input wire logic [3:0] cur_drop,
   // sensing out
   output fsl_chin_s chin
);
   // ------------------------------------------------------------
   // load current follows amplitude; a drop halves it
   // ------------------------------------------------------------
   always_comb
   begin
      chin.hw_fault = fault_req;
      chin.int_err = int_req;
      chin.connect = 4'h0;
      for (int i = 0; i < NCH; i++)
      begin
         chin.cur[i] = cur_drop[i] ? {2'b00, lamp_amp[i][6:1]} : {1'b0, lamp_amp[i]};
      end
   end
endmodule

/* fsl_tb.sv */
`timescale 1ns/100ps
module testbench
   import fsl_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] mode_contact = 5'h00;
   logic [1:0] flash_in = 2'h0;
   logic dip_collective = 1'b0;
   logic reset_key = 1'b0;
   logic [3:0] fault_req = 4'h0;
   logic [3:0] int_req = 4'h0;
   logic [3:0] cur_drop = 4'h0;
   fsl_chin_s chin;
   logic [3:0][6:0] lamp_amp;
   fsl_flt_s flt;
   logic [31:0] q;
   logic e;
   int fails = 0;
   int tests_run = 0;

   always #2 pclk = ~pclk;

   fsl_lamp_ctrl #(.TICK_CYC(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_contact(mode_contact),
      .flash_in(flash_in), .dip_collective(dip_collective), .reset_key(reset_key),
      .chin(chin), .lamp_amp(lamp_amp), .flt(flt));

   fsl_lamp_chain u_chain (.lamp_amp(lamp_amp), .fault_req(fault_req), .int_req(int_req),
      .cur_drop(cur_drop), .chin(chin));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic lamps(input logic [27:0] exp);
      chk({4'h0, lamp_amp}, {4'h0, exp});
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      cyc(10);
      chk({8'h00, flt}, {8'h00, 4'h0, 4'h0, 16'hFFFF});
      cyc(2);
      presetn <= 1'b1;
      cyc(4);
      chk({8'h00, flt}, {8'h00, 4'hF, 4'h0, 16'hFFFF});
      lamps({7'h64, 7'h64, 7'h64, 7'h64});
      $display("test reset done");
   endtask

   task automatic t_regs();
      apb(1'b0, A_THR, 32'h0);
      chk(q, 32'h14);
      apb(1'b1, A_THR, 32'h7F);
      apb(1'b0, A_THR, 32'h0);
      chk(q, 32'h63);
      apb(1'b1, A_THR, 32'h0);
      apb(1'b0, A_THR, 32'h0);
      chk(q, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, A_THR, 32'h14);
      $display("test regs done");
   endtask

   task automatic t_func();
      apb(1'b1, 8'h44, 32'hF1);
      apb(1'b1, 8'h48, 32'h4);
      cyc(3);
      lamps({7'h64, 7'h00, 7'h1E, 7'h64});
      $display("test func done");
   endtask

   task automatic t_mode();
      apb(1'b1, 8'h60, 32'h4);
      mode_contact <= 5'b00110;
      cyc(3);
      apb(1'b0, A_STAT, 32'h0);
      chk(q & 32'h7, 32'h2);
      lamps({7'h64, 7'h64, 7'h64, 7'h00});
      mode_contact <= 5'b10110;
      cyc(3);
      apb(1'b0, A_STAT, 32'h0);
      chk(q & 32'h7, 32'h4);
      lamps({7'h64, 7'h64, 7'h64, 7'h64});
      mode_contact <= 5'b00000;
      cyc(3);
      apb(1'b0, A_STAT, 32'h0);
      chk(q & 32'h7, 32'h0);
      lamps({7'h64, 7'h00, 7'h1E, 7'h64});
      $display("test mode done");
   endtask

   task automatic t_fault();
      fault_req <= 4'h8;
      cyc(3);
      fault_req <= 4'h0;
      cyc(3);
      lamps({7'h00, 7'h00, 7'h1E, 7'h64});
      chk({8'h00, flt}, {8'h00, 4'h7, 4'h8, 16'hE041});
      reset_key <= 1'b1;
      cyc(1);
      reset_key <= 1'b0;
      cyc(3);
      chk({8'h00, flt}, {8'h00, 4'hF, 4'h0, 16'hFFFF});
      dip_collective <= 1'b1;
      fault_req <= 4'h1;
      cyc(3);
      fault_req <= 4'h0;
      chk({8'h00, flt}, {8'h00, 4'h0, 4'h1, 16'hE011});
      apb(1'b1, A_CTRL, 32'h2);
      cyc(3);
      chk({8'h00, flt}, {8'h00, 4'hF, 4'h0, 16'hFFFF});
      dip_collective <= 1'b0;
      $display("test fault done");
   endtask

   task automatic t_flash();
      flash_in <= 2'b01;
      cyc(3);
      lamps({7'h64, 7'h64, 7'h64, 7'h64});
      flash_in <= 2'b00;
      cyc(3);
      lamps({7'h00, 7'h00, 7'h00, 7'h00});
      apb(1'b1, A_CTRL, 32'h1);
      flash_in <= 2'b01;
      cyc(3);
      lamps({7'h64, 7'h64, 7'h64, 7'h64});
      flash_in <= 2'b11;
      cyc(3);
      flash_in <= 2'b01;
      cyc(3);
      lamps({7'h00, 7'h00, 7'h00, 7'h00});
      cyc(19900);
      lamps({7'h00, 7'h00, 7'h00, 7'h00});
      cyc(200);
      lamps({7'h64, 7'h00, 7'h1E, 7'h64});
      $display("test flash done");
   endtask

   task automatic t_rate();
      cur_drop <= 4'h1;
      cyc(30);
      chk({25'h0, lamp_amp[0]}, 32'h64);
      chk({8'h00, flt}, {8'h00, 4'hE, 4'h1, 16'hE010});
      apb(1'b1, A_THR, 32'h14);
      reset_key <= 1'b1;
      cyc(1);
      reset_key <= 1'b0;
      cyc(30);
      chk({8'h00, flt}, {8'h00, 4'hF, 4'h0, 16'hFFFF});
      cur_drop <= 4'h0;
      int_req <= 4'h2;
      cyc(3);
      int_req <= 4'h0;
      chk({8'h00, flt}, {8'h00, 4'hD, 4'h2, 16'hE022});
      reset_key <= 1'b1;
      cyc(1);
      reset_key <= 1'b0;
      cyc(3);
      chk({8'h00, flt}, {8'h00, 4'hF, 4'h0, 16'hFFFF});
      $display("test rate done");
   endtask

   task automatic t_wave();
      int lit2;
      int lit3;
      int up2;
      int up3;
      logic [6:0] p2;
      logic [6:0] p3;
      lit2 = 0;
      lit3 = 0;
      up2 = 0;
      up3 = 0;
      // channel 2 blinks at 5 Hz, channel 3 flashes 5 ms wide
      apb(1'b1, 8'h48, 32'h192);
      apb(1'b1, 8'h4C, 32'h2B);
      cyc(20);
      p2 = lamp_amp[2];
      p3 = lamp_amp[3];
      // one full second of the 1 ms time base
      repeat (10000)
      begin
         @(posedge pclk);
         if (lamp_amp[2] == AMP_FULL)
            lit2++;
         if (lamp_amp[3] == AMP_FULL)
            lit3++;
         if (lamp_amp[2] == AMP_FULL && p2 != AMP_FULL)
            up2++;
         if (lamp_amp[3] == AMP_FULL && p3 != AMP_FULL)
            up3++;
         p2 = lamp_amp[2];
         p3 = lamp_amp[3];
      end
      chk(lit2, 32'h1388);
      chk(up2, 32'h5);
      chk(lit3, 32'h32);
      chk(up3, 32'h1);
      apb(1'b1, 8'h48, 32'h4);
      apb(1'b1, 8'h4C, 32'h0);
      $display("test wave done");
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      t_reset();
      t_regs();
      t_func();
      t_mode();
      t_fault();
      t_rate();
      t_wave();
      t_flash();
      end_of_test();
   end

   initial
   begin
      cyc(40000);
      fails++;
      end_of_test();
   end
endmodule
